// ### core/mtm_defines.svh
// Register offsets, field positions, source codes and reset values for the modulo timer.
// What this block does
// R1: Interrupt request when flag and enable set.
// R2: Software clears flag before setting enable.
// R3: Counter-reset bit zeroes count and flag.
// R4: Halt bit freezes count; set by reset.
// R5: Unused control and clock bits read zero.
// R6: Source field picks bus, fixed, pin edges.
// R7: Source change keeps the count running.
// R8: Prescaler divides by two to field power, by 256 for codes eight and up.
// R9: Prescaler change keeps the count running.
// R10: Count register is read-only, reset zero.
// R11: Modulo zero means free-running full range.
// R12: Any modulo write zeroes count and flag.
// R13: Count up to modulo, then roll over.
// R14: Flag sets on modulo-to-zero transition.
// R15: Flag clears by read then zero write.
// R16: Reset leaves timer stopped with defaults.
// R17: Software clears halt to start counting.
// R18: Nonzero modulo while running is modulo mode.
// R19: Pin synchronised; at most quarter bus rate.
// R20: Debug mode suspends counting, then resumes.
// R21: Request is flag AND enable, a level.
`ifndef MTM_DEFINES_SVH
`define MTM_DEFINES_SVH
`define MTM_OFF_STATUS_CONTROL 12'h000
`define MTM_OFF_CLOCK_CONFIG 12'h004
`define MTM_OFF_COUNT_VALUE 12'h008
`define MTM_OFF_MODULO_VALUE 12'h00c
`define MTM_BIT_FLAG 7
`define MTM_BIT_IRQ_EN 6
`define MTM_BIT_CNT_RST 5
`define MTM_BIT_HALT 4
`define MTM_CLOCK_SOURCE_SELECT_HI 5
`define MTM_CLOCK_SOURCE_SELECT_LO 4
`define MTM_PS_HI 3
`define MTM_PS_LO 0
`define MTM_PS_MAX 4'h8
`define MTM_SRC_BUS 2'h0
`define MTM_SRC_FIXED 2'h1
`define MTM_SRC_PIN_FALL 2'h2
`define MTM_SRC_PIN_RISE 2'h3
`define MTM_RST_COUNT 8'h00
`define MTM_RST_MODULO 8'h00
`define MTM_RST_CLKCFG 6'h00
`endif

// ### core/mtm_pkg.sv
// Types shared by the modulo timer.
package mtm_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mtm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mtm_apb_rsp_t;

  typedef enum logic [1:0] {
    MTM_CLR_IDLE = 2'b00,
    MTM_CLR_ARMED = 2'b01
  } mtm_clr_t;

  typedef struct packed {
    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt;
    logic [1:0] clock_source_select;
    logic [3:0] prescale_select;
    logic [7:0] count;
    logic [7:0] modulo_field;
    logic [7:0] prescaler;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_prev;
    mtm_clr_t clr_state;
    logic [31:0] prdata;
  } mtm_state_t;
endpackage : mtm_pkg

// ### core/mtm_timer.sv
// Modulo timer core with its APB register slave.
`timescale 1ns/10ps
`include "mtm_defines.svh"
module mtm_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire mtm_pkg::mtm_apb_req_t apb_req,
  output mtm_pkg::mtm_apb_rsp_t apb_rsp,
  // Timer clock and debug inputs
  input wire logic fixed_frequency_clock,
  input wire logic external_timer_clock_pin,
  input wire logic debug_active,
  // Interrupt request
  output logic timer_irq
);
  import mtm_pkg::*;

  mtm_state_t st;
  mtm_state_t next_st;

  // Prescaler tap for a given divide code; codes past eight divide by 256.
  function automatic logic tap_tick(input logic [7:0] pre, input logic [3:0] ps);
    logic t;
    t = 1'b1;
    if (ps == 4'h0)
    begin
      t = 1'b1;
    end
    else if (ps >= `MTM_PS_MAX)
    begin
      t = &pre;
    end
    else
    begin
      t = &(pre | ~((8'h01 << ps[2:0]) - 8'h01));
    end
    return t;
  endfunction : tap_tick

  logic wr_acc;
  logic rd_acc;
  logic src_edge;
  logic tick;
  logic [7:0] sc_read;
  logic [7:0] clk_read;

  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  // R5 unused bits zero
  assign sc_read = {st.overflow_flag, st.overflow_irq_enable, 1'b0, st.counter_halt, 4'h0};
  assign clk_read = {2'b00, st.clock_source_select, st.prescale_select};

  always_comb
  begin
    next_st = st;
    src_edge = 1'b0;
    tick = 1'b0;
    // R19 two-stage pin synchroniser
    next_st.pin_sync1 = external_timer_clock_pin;
    next_st.pin_sync2 = st.pin_sync1;
    next_st.pin_prev = st.pin_sync2;
    // R6 source selection
    case (st.clock_source_select)
      `MTM_SRC_BUS: src_edge = 1'b1;
      `MTM_SRC_FIXED: src_edge = fixed_frequency_clock;
      `MTM_SRC_PIN_FALL: src_edge = st.pin_prev & ~st.pin_sync2;
      default: src_edge = st.pin_sync2 & ~st.pin_prev;
    endcase
    // R4 halt freezes; R20 debug suspends
    if (!st.counter_halt && !debug_active && src_edge)
    begin
      // R8 binary prescaler tap; R7 R9 changes keep the count
      tick = tap_tick(st.prescaler, st.prescale_select);
      next_st.prescaler = st.prescaler + 8'h01;
    end
    if (tick)
    begin
      // R13 R18 modulo compare; R11 zero is full range
      if (st.modulo_field != 8'h00 && st.count == st.modulo_field)
      begin
        next_st.count = 8'h00;
      end
      else
      begin
        next_st.count = st.count + 8'h01;
      end
    end
    // R15 a read with the flag set arms the clear
    if (rd_acc && apb_req.paddr == `MTM_OFF_STATUS_CONTROL && st.overflow_flag)
    begin
      next_st.clr_state = MTM_CLR_ARMED;
    end
    next_st.prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      if (apb_req.paddr == `MTM_OFF_STATUS_CONTROL)
      begin
        next_st.prdata = {24'h00_0000, sc_read};
      end
      else if (apb_req.paddr == `MTM_OFF_CLOCK_CONFIG)
      begin
        next_st.prdata = {24'h00_0000, clk_read};
      end
      else if (apb_req.paddr == `MTM_OFF_COUNT_VALUE)
      begin
        // R10 live count read
        next_st.prdata = {24'h00_0000, st.count};
      end
      else if (apb_req.paddr == `MTM_OFF_MODULO_VALUE)
      begin
        next_st.prdata = {24'h00_0000, st.modulo_field};
      end
    end
    if (wr_acc)
    begin
      if (apb_req.paddr == `MTM_OFF_STATUS_CONTROL)
      begin
        next_st.overflow_irq_enable = apb_req.pwdata[`MTM_BIT_IRQ_EN];
        next_st.counter_halt = apb_req.pwdata[`MTM_BIT_HALT];
        // R15 second step clears only when armed
        if (!apb_req.pwdata[`MTM_BIT_FLAG] && st.clr_state == MTM_CLR_ARMED)
        begin
          next_st.overflow_flag = 1'b0;
        end
        next_st.clr_state = MTM_CLR_IDLE;
        // R3 counter reset
        if (apb_req.pwdata[`MTM_BIT_CNT_RST])
        begin
          next_st.count = 8'h00;
          next_st.prescaler = 8'h00;
          next_st.overflow_flag = 1'b0;
        end
      end
      else if (apb_req.paddr == `MTM_OFF_CLOCK_CONFIG)
      begin
        next_st.clock_source_select = apb_req.pwdata[`MTM_CLOCK_SOURCE_SELECT_HI:`MTM_CLOCK_SOURCE_SELECT_LO];
        next_st.prescale_select = apb_req.pwdata[`MTM_PS_HI:`MTM_PS_LO];
      end
      else if (apb_req.paddr == `MTM_OFF_MODULO_VALUE)
      begin
        // R12 modulo write resets count and flag
        next_st.modulo_field = apb_req.pwdata[7:0];
        next_st.count = 8'h00;
        next_st.prescaler = 8'h00;
        next_st.overflow_flag = 1'b0;
      end
    end
    // R14 R15 overflow sets the flag and wins over a clear write, not over a modulo or count-reset write; disarms any pending clear
    if (tick && st.modulo_field != 8'h00 && st.count == st.modulo_field
        && !(wr_acc && apb_req.paddr == `MTM_OFF_MODULO_VALUE)
        && !(wr_acc && apb_req.paddr == `MTM_OFF_STATUS_CONTROL
             && apb_req.pwdata[`MTM_BIT_CNT_RST]))
    begin
      next_st.overflow_flag = 1'b1;
      next_st.clr_state = MTM_CLR_IDLE;
    end
    else if (tick && st.modulo_field == 8'h00 && st.count == 8'hff
        && !(wr_acc && apb_req.paddr == `MTM_OFF_MODULO_VALUE)
        && !(wr_acc && apb_req.paddr == `MTM_OFF_STATUS_CONTROL
             && apb_req.pwdata[`MTM_BIT_CNT_RST]))
    begin
      next_st.overflow_flag = 1'b1;
      next_st.clr_state = MTM_CLR_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // R16 reset state
      st <= '0;
      st.counter_halt <= 1'b1;
      st.count <= `MTM_RST_COUNT;
      st.modulo_field <= `MTM_RST_MODULO;
      {st.clock_source_select, st.prescale_select} <= `MTM_RST_CLKCFG;
      st.clr_state <= MTM_CLR_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // R1 R21 level request
  assign timer_irq = st.overflow_flag & st.overflow_irq_enable;

  // Read data is registered in the first access cycle, so reads answer one cycle late.
  logic rd_wait;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_wait <= 1'b0;
    end
    else
    begin
      rd_wait <= rd_acc & ~rd_wait;
    end
  end

  always_comb
  begin
    apb_rsp.pready = apb_req.pwrite ? 1'b1 : rd_wait;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata = st.prdata;
  end
endmodule : mtm_timer

// ### sim/mtm_properties.sv
// Port-level checks for the modulo timer.
`timescale 1ns/10ps
module mtm_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire mtm_pkg::mtm_apb_req_t apb_req,
  input wire mtm_pkg::mtm_apb_rsp_t apb_rsp,
  // Timer pins
  input wire logic fixed_frequency_clock,
  input wire logic external_timer_clock_pin,
  input wire logic debug_active,
  input wire logic timer_irq
);
  import mtm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = apb_req.psel & apb_req.penable;
  wire wr = acc & apb_req.pwrite;
  wire rd = acc & ~apb_req.pwrite & apb_rsp.pready;
  wire sc = apb_req.paddr == 12'h000;
  wire [7:0] d = apb_req.pwdata[7:0];
  wr_ready_a: assert property (wr |-> apb_rsp.pready)
    else $error("write access not ready");
  rd_wait_a: assert property (acc & ~apb_req.pwrite & ~$past(apb_req.penable)
    |-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("read wait wrong");
  rd_upper_a: assert property (rd |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  sc_unused_a: assert property (rd & sc |-> apb_rsp.prdata[3:0] == 4'h0 &&
    !apb_rsp.prdata[5]) else $error("status spare bits set");
  clk_unused_a: assert property (rd & apb_req.paddr == 12'h004
    |-> apb_rsp.prdata[7:6] == 2'h0) else $error("clock spare bits set");
  irq_off_a: assert property (wr & sc & !d[6] |=> !timer_irq)
    else $error("irq with enable off");
  irq_trst_a: assert property (wr & sc & d[5] |=> !timer_irq)
    else $error("irq after count reset");
  irq_mod_a: assert property (wr & apb_req.paddr == 12'h00c |=> !timer_irq)
    else $error("irq after modulo write");
  cover property ($rose(timer_irq));
  cover property (wr & sc & d[5]);
  cover property (rd & apb_req.paddr == 12'h008);
endmodule : mtm_properties
bind mtm_timer mtm_properties u_mtm_properties (.clk(clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .fixed_frequency_clock(fixed_frequency_clock),
  .external_timer_clock_pin(external_timer_clock_pin), .debug_active(debug_active),
  .timer_irq(timer_irq));

// ### sim/tb.sv
// Register-level testbench of the modulo timer.
`timescale 1ns/10ps
module tb;
  import mtm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ffc = 1'b0;
  logic pin = 1'b0;
  logic dbg = 1'b0;
  logic irq;
  logic [1:0] ph = 2'h0;
  logic [7:0] r;
  logic [7:0] e;
  int sh;
  int n_fail = 0;
  int num_checks = 0;
  mtm_apb_req_t q = '0;
  mtm_apb_rsp_t s;
  mtm_timer u_mtm_timer (.clk(clk), .rst(rst), .apb_req(q), .apb_rsp(s),
    .fixed_frequency_clock(ffc), .external_timer_clock_pin(pin),
    .debug_active(dbg), .timer_irq(irq));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    ffc <= ~ffc;
    ph <= ph + 2'h1;
    pin <= ph[1];
  end
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] v, input logic [7:0] x);
    num_checks++;
    if (v !== x)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, v, x);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    q <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    q.penable <= 1'b1;
    // The request stands until pready is sampled high at a rising edge.
    do
    begin
      @(posedge clk);
      n++;
    end while (s.pready !== 1'b1 && n < 9);
    if (s.pready !== 1'b1)
    begin
      chk(8'h00, 8'h01);
      end_sim();
    end
    r = s.prdata[7:0];
    q <= '0;
  endtask : xf
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    xf(1'b0, a, 8'h00);
    chk(r, x);
  endtask : rc
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rc(12'(i * 4), i ? 8'h00 : 8'h10);
    xf(1'b1, 12'h008, 8'h55);
    rc(12'h008, 8'h00);
    $display("reset test done");
    xf(1'b1, 12'h00c, 8'h03);
    xf(1'b1, 12'h000, 8'h00);
    repeat (8) @(posedge clk);
    rc(12'h000, 8'h80);
    repeat (4) @(posedge clk);
    xf(1'b1, 12'h000, 8'h10);
    rc(12'h000, 8'h90);
    xf(1'b1, 12'h000, 8'h10);
    rc(12'h000, 8'h10);
    xf(1'b0, 12'h008, 8'h00);
    e = r;
    repeat (5) @(posedge clk);
    rc(12'h008, e);
    $display("flag test done");
    xf(1'b1, 12'h00c, 8'h03);
    xf(1'b1, 12'h000, 8'h40);
    repeat (8) @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    xf(1'b1, 12'h000, 8'h70);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    rc(12'h000, 8'h50);
    $display("irq test done");
    for (int i = 0; i < 15; i++)
    begin
      dbg <= (i == 14);
      sh = i > 9 ? (i > 12 ? 2 : i - 10) : (i > 8 ? 8 : i);
      xf(1'b1, 12'h00c, 8'h00);
      xf(1'b1, 12'h004, i < 10 ? 8'(i) : {2'h0, i[1:0] - 2'h2, 4'h0});
      xf(1'b1, 12'h000, 8'h00);
      repeat (997) @(posedge clk);
      xf(1'b1, 12'h000, 8'h10);
      xf(1'b0, 12'h008, 8'h00);
      e = i == 14 ? 8'h00 : 8'(1000 >> sh);
      chk({7'h0, 8'(r - e + 8'h01) <= 8'h02}, 8'h01);
    end
    $display("rate test done");
    end_sim();
  end
endmodule : tb
